/* tces_pkg.sv */
// Shared constants for the tape control ending, scan and selection sequencer
package tces_pkg;
    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_SENSE = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_STATE = 4'h3;
    localparam int CTRL_DIAG_BIT = 0;
    localparam int CTRL_LAST_LSB = 1;
    localparam logic [7:0] CTRL_RESET = 8'h0E;
    // --------------------------------------------------------------
    // Sense byte bits
    // --------------------------------------------------------------
    localparam int SN_CMD_REJ = 0;
    localparam int SN_BUS_CHK = 1;
    localparam int SN_TU_REJ = 2;
    localparam int SN_VEL = 3;
    localparam int SN_TACH_STOP = 4;
    localparam int SN_BACK_BOT = 5;
    localparam int SN_ALU = 6;
    localparam int SN_ILLEGAL = 7;
    // --------------------------------------------------------------
    // Unit status bits
    // --------------------------------------------------------------
    localparam int ST_UC = 1;
    localparam int ST_DE = 2;
    localparam int ST_CE = 3;
    // --------------------------------------------------------------
    // Command codes
    // --------------------------------------------------------------
    localparam logic [7:0] CMD_TEST_IO = 8'h00;
    localparam logic [7:0] CMD_WRITE = 8'h01;
    localparam logic [7:0] CMD_READ = 8'h02;
    localparam logic [7:0] CMD_SENSE = 8'h04;
    localparam logic [7:0] CMD_REWIND = 8'h07;
    localparam logic [7:0] CMD_ERASE_GAP = 8'h17;
    localparam logic [7:0] CMD_BACKSPACE = 8'h27;
    localparam logic [7:0] CMD_SECURE_ERASE = 8'h97;
    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_KHZ = 200000;
    localparam int TACH_STOP_MS = 5;
    localparam int TACH_STOP_CYC = TACH_STOP_MS * CLK_KHZ;
    localparam int TACH_MIN_CYC = 200;
    localparam int TACH_MAX_CYC = 2000;
    localparam logic [7:0] ALU_PATTERN = 8'hA5;
    localparam logic [7:0] ALU_ALL_ONES = 8'hFF;
    // --------------------------------------------------------------
    // Sequencer states
    // --------------------------------------------------------------
    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_SELECT = 8'h02,
        S_RUN = 8'h04,
        S_STOP = 8'h08,
        S_DIAG = 8'h10,
        S_TERM = 8'h20,
        S_PRESENT = 8'h40,
        S_CLEAN = 8'h80
    } tces_state_t;
endpackage : tces_pkg

/* tces_ctrl.sv */
// Tape control ending sequence, idle scan loop and initial selection
// Summary of operation
// - On end: drop tags, sense, diagnose, idle
// - No tach pulse 5 ms: tach stop
// - Tach interval too short/long: velocity check
// - Unit not ready or start off: reject
// - Backward command at load point: error
// - After sense checks, self-test ALU, record failure
// - Any sense bit gives unit check
// - Chained operation: withhold status, await next
// - Device end except rewind and secure erase
// - Adapter select during ending takes priority
// - Pending status or test IO: present status
// - Otherwise, or halt with pending: reset tags
// - Metering active during rewind or secure erase
// - Unaccepted status is stacked and kept pending
// - Secure erase legal only chained from erase gap
// - Command out sampled; halt IO terminates operation
// - Idle scan drives metering from device-end primes
// - Failed secure erase: device end plus check
// - Completed rewind or erase: device end alone
// - Idle scan steps unit address up to last, then wraps to 0
// - Command byte parity checked before decode
// - Invalid command: illegal sense and reject
`timescale 1ns/1ps
module tces_ctrl
    import tces_pkg::*;
#(
    parameter int P_TACH_STOP_CYC = TACH_STOP_CYC,
    parameter int P_UNITS = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_adapter_select,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_byte,
    input wire logic i_cmd_parity,
    input wire logic i_cmd_chained,
    input wire logic i_command_out,
    input wire logic i_halt_io_request,
    input wire logic i_status_accept,
    input wire logic i_status_stack,
    input wire logic i_op_done,
    input wire logic i_tach_pulse,
    input wire logic i_tu_ready,
    input wire logic i_tu_start,
    input wire logic i_at_load_point,
    input wire logic i_tu_interrupt,
    input wire logic i_tu_erase_fail,
    input wire logic [P_UNITS-1:0] i_de_prime,
    output logic o_service_in,
    output logic o_move_tag,
    output logic o_status_valid,
    output logic [7:0] o_status_byte,
    output logic o_tags_reset,
    output logic o_metering_in,
    output logic [2:0] o_tu_addr
);
    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    function automatic logic cmd_known(input logic [7:0] c);
        cmd_known = (c == CMD_TEST_IO) || (c == CMD_WRITE) || (c == CMD_READ) ||
            (c == CMD_SENSE) || (c == CMD_REWIND) || (c == CMD_ERASE_GAP) ||
            (c == CMD_BACKSPACE) || (c == CMD_SECURE_ERASE);
    endfunction : cmd_known

    function automatic logic cmd_long(input logic [7:0] c);
        cmd_long = (c == CMD_REWIND) || (c == CMD_SECURE_ERASE);
    endfunction : cmd_long

    tces_state_t state_reg, state_next;
    logic [7:0] ctrl_reg, sense_reg, pend_reg, cmd_reg;
    logic [2:0] unit_reg;
    logic halt_reg, long_op_reg, tach_seen_reg;
    logic [23:0] tach_cnt_reg;
    logic parity_ok, test_io_request, alu_fail, halt_seen;

    // Odd parity over byte plus parity bit
    assign parity_ok = ^{i_cmd_byte, i_cmd_parity};
    assign test_io_request = (cmd_reg == CMD_TEST_IO);
    assign halt_seen = i_command_out && i_halt_io_request;
    // ALU check: x + ~x must give all ones; control bit injects a fault
    assign alu_fail = ((8'(ALU_PATTERN + ~ALU_PATTERN)) != ALU_ALL_ONES) ||
        ctrl_reg[CTRL_DIAG_BIT];

    // ----------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE: begin
                if (i_adapter_select) begin
                    state_next = S_SELECT;
                end
            end
            S_SELECT: begin
                if (i_cmd_valid) begin
                    if (!parity_ok || !cmd_known(i_cmd_byte) ||
                        (i_cmd_byte == CMD_SECURE_ERASE &&
                        !(i_cmd_chained && cmd_reg == CMD_ERASE_GAP)) ||
                        i_cmd_byte == CMD_TEST_IO) begin
                        state_next = S_TERM;
                    end else begin
                        state_next = S_RUN;
                    end
                end
            end
            S_RUN: begin
                if (i_op_done || halt_seen) begin
                    state_next = S_STOP;
                end
            end
            S_STOP: state_next = S_DIAG;
            S_DIAG: state_next = S_TERM;
            S_TERM: begin
                if (i_adapter_select) begin
                    state_next = S_SELECT;
                end else if (i_cmd_chained && sense_reg == 8'h00 && !halt_reg) begin
                    state_next = S_SELECT;
                end else if ((pend_reg != 8'h00 || sense_reg != 8'h00 || test_io_request) && !halt_reg) begin
                    state_next = S_PRESENT;
                end else begin
                    state_next = S_CLEAN;
                end
            end
            S_PRESENT: begin
                if (i_status_accept || i_status_stack) begin
                    state_next = S_CLEAN;
                end
            end
            S_CLEAN: state_next = S_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Command capture and chaining history
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cmd_reg <= CMD_TEST_IO;
        end else if (state_reg == S_SELECT && i_cmd_valid) begin
            cmd_reg <= i_cmd_byte;
        end
    end

    // Halt IO latch, cleared on a new selection
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            halt_reg <= 1'b0;
        end else if (state_reg == S_RUN && halt_seen) begin
            halt_reg <= 1'b1;
        end else if (state_reg == S_SELECT) begin
            halt_reg <= 1'b0;
        end
    end

    // Tachometer interval timer, runs while tape is commanded to move
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tach_cnt_reg <= 24'h000000;
            tach_seen_reg <= 1'b0;
        end else if (state_reg == S_RUN) begin
            if (i_tach_pulse) begin
                tach_cnt_reg <= 24'h000000;
                tach_seen_reg <= 1'b1;
            end else if (tach_cnt_reg < 24'(P_TACH_STOP_CYC)) begin
                tach_cnt_reg <= tach_cnt_reg + 24'h000001;
            end
        end else begin
            tach_cnt_reg <= 24'h000000;
            tach_seen_reg <= 1'b0;
        end
    end

    // Sense byte: cleared when selected from idle, errors accumulate through the operation
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sense_reg <= 8'h00;
        end else if (state_reg == S_IDLE && i_adapter_select) begin
            sense_reg <= 8'h00;
        end else begin
            if (state_reg == S_SELECT && i_cmd_valid) begin
                if (!parity_ok) begin
                    sense_reg[SN_BUS_CHK] <= 1'b1;
                end else if (!cmd_known(i_cmd_byte) ||
                    (i_cmd_byte == CMD_SECURE_ERASE &&
                    !(i_cmd_chained && cmd_reg == CMD_ERASE_GAP))) begin
                    sense_reg[SN_ILLEGAL] <= 1'b1;
                    sense_reg[SN_CMD_REJ] <= 1'b1;
                end
            end
            if (state_reg == S_RUN) begin
                if (tach_cnt_reg >= 24'(P_TACH_STOP_CYC)) begin
                    sense_reg[SN_TACH_STOP] <= 1'b1;
                end
                if (i_tach_pulse && tach_seen_reg && (tach_cnt_reg < 24'(TACH_MIN_CYC) ||
                    tach_cnt_reg > 24'(TACH_MAX_CYC))) begin
                    sense_reg[SN_VEL] <= 1'b1;
                end
            end
            if (state_reg == S_STOP) begin
                if (!i_tu_ready || !i_tu_start) begin
                    sense_reg[SN_TU_REJ] <= 1'b1;
                end
                if (cmd_reg == CMD_BACKSPACE && i_at_load_point) begin
                    sense_reg[SN_BACK_BOT] <= 1'b1;
                end
            end
            if (state_reg == S_DIAG && alu_fail) begin
                sense_reg[SN_ALU] <= 1'b1;
            end
        end
    end

    // Pending status: built at the ending, from unit interrupts in the scan;
    // cleared on acceptance or by chaining, kept when stacked, a set wins over a clear
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_reg <= 8'h00;
        end else begin
            if ((state_reg == S_PRESENT && i_status_accept) ||
                (state_reg == S_TERM && state_next == S_SELECT && !i_adapter_select)) begin
                pend_reg <= 8'h00;
            end
            if (state_reg == S_DIAG) begin
                pend_reg[ST_CE] <= 1'b1;
                pend_reg[ST_UC] <= (sense_reg != 8'h00) || alu_fail;
                if (!cmd_long(cmd_reg)) begin
                    pend_reg[ST_DE] <= 1'b1;
                end
            end else if (state_reg == S_TERM && sense_reg != 8'h00) begin
                pend_reg[ST_UC] <= 1'b1;
            end
            if (state_reg == S_IDLE && i_tu_interrupt && long_op_reg) begin
                pend_reg[ST_DE] <= 1'b1;
                if (i_tu_erase_fail && cmd_reg == CMD_SECURE_ERASE) begin
                    pend_reg[ST_UC] <= 1'b1;
                end
            end
        end
    end

    // Long operation tracking for metering and deferred device end
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            long_op_reg <= 1'b0;
        end else if (state_reg == S_RUN && cmd_long(cmd_reg)) begin
            long_op_reg <= 1'b1;
        end else if (state_reg == S_IDLE && i_tu_interrupt) begin
            long_op_reg <= 1'b0;
        end
    end

    // Idle scan unit address
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            unit_reg <= 3'h0;
        end else if (state_reg == S_IDLE && !i_adapter_select && pend_reg == 8'h00 &&
            !i_tu_interrupt) begin
            if (unit_reg != ctrl_reg[CTRL_LAST_LSB +: 3]) begin
                unit_reg <= unit_reg + 3'h1;
            end else begin
                unit_reg <= 3'h0;
            end
        end
    end

    // Interface tags toward host and tape unit
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_service_in <= 1'b0;
            o_move_tag <= 1'b0;
            o_tags_reset <= 1'b0;
            o_status_valid <= 1'b0;
            o_status_byte <= 8'h00;
        end else begin
            o_service_in <= (state_next == S_RUN);
            o_move_tag <= (state_next == S_RUN);
            o_tags_reset <= (state_next == S_CLEAN);
            o_status_valid <= (state_next == S_PRESENT);
            o_status_byte <= (state_next == S_PRESENT) ? pend_reg : 8'h00;
        end
    end

    // Metering line and unit address
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_metering_in <= 1'b0;
            o_tu_addr <= 3'h0;
        end else begin
            o_metering_in <= long_op_reg || (|i_de_prime);
            o_tu_addr <= unit_reg;
        end
    end

    // ----------------------------------------------------------
    // Register port
    // ----------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg <= CTRL_RESET;
        end else if (i_wr && i_addr == ADDR_CTRL) begin
            ctrl_reg <= i_wdata;
        end
    end

    // Read data, valid the cycle after the strobe
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                ADDR_CTRL: o_rdata <= ctrl_reg;
                ADDR_SENSE: o_rdata <= sense_reg;
                ADDR_STATUS: o_rdata <= pend_reg;
                ADDR_STATE: o_rdata <= state_reg;
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------
    // Checks
    // ----------------------------------------------------------
    sequence s_stop_seen;
        state_reg == S_STOP;
    endsequence

    sequence s_tags_dropped;
        !o_service_in && !o_move_tag;
    endsequence

    ending_tags_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_stop_seen |-> s_tags_dropped ##2 state_reg == S_TERM)
        else $error("tags not dropped at ending");

    tach_stop_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        state_reg == S_RUN && tach_cnt_reg >= 24'(P_TACH_STOP_CYC) |=> sense_reg[SN_TACH_STOP])
        else $error("stopped capstan not flagged");

    tu_reject_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        state_reg == S_STOP && !i_tu_ready |=> sense_reg[SN_TU_REJ])
        else $error("tape unit reject missing");

    unit_check_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        state_reg == S_DIAG && sense_reg != 8'h00 |=> pend_reg[ST_UC])
        else $error("unit check missing from status");

    defer_de_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        state_reg == S_DIAG && cmd_long(cmd_reg) && !$past(pend_reg[ST_DE]) &&
        !pend_reg[ST_DE] |=> !pend_reg[ST_DE])
        else $error("device end not deferred");

    select_prio_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        state_reg == S_TERM && i_adapter_select |=> state_reg == S_SELECT && !o_status_valid)
        else $error("selection lost priority");

    stack_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        state_reg == S_PRESENT && i_status_stack && !i_status_accept && pend_reg != 8'h00
        |=> pend_reg != 8'h00 && o_tags_reset)
        else $error("stacked status dropped");

    halt_term_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        state_reg == S_RUN && halt_seen |=> state_reg == S_STOP ##[1:3] state_reg == S_TERM)
        else $error("halt did not terminate");

    illegal_cmd_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        state_reg == S_SELECT && i_cmd_valid && parity_ok && !cmd_known(i_cmd_byte)
        |=> sense_reg[SN_ILLEGAL] && sense_reg[SN_CMD_REJ] && state_reg == S_TERM)
        else $error("invalid command not rejected");

    scan_step_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        state_reg == S_IDLE && !i_adapter_select && pend_reg == 8'h00 && !i_tu_interrupt &&
        unit_reg != ctrl_reg[CTRL_LAST_LSB +: 3] |=> unit_reg == $past(unit_reg) + 3'h1)
        else $error("scan did not advance");
endmodule : tces_ctrl

/* tces_host_model.sv */
// Host channel adapter model: selection, command bytes, halt and status answers
`timescale 1ns/1ps
module tces_host_model (
    input wire logic i_core_clk,
    input wire logic i_status_valid,
    output logic o_adapter_select,
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_byte,
    output logic o_cmd_parity,
    output logic o_cmd_chained,
    output logic o_command_out,
    output logic o_halt_io_request,
    output logic o_status_accept,
    output logic o_status_stack
);
    logic stack_mode = 1'b0;
    int dly = 2;
    int cnt = 0;
    // ----------------------------------------------------------
    // Idle levels at time zero
    // ----------------------------------------------------------
    initial begin
        o_adapter_select = 1'b0;
        o_cmd_valid = 1'b0;
        o_cmd_byte = 8'h00;
        o_cmd_parity = 1'b1;
        o_cmd_chained = 1'b0;
        o_command_out = 1'b0;
        o_halt_io_request = 1'b0;
    end
    // Answer offered status after a delay, accepting or stacking it
    always @(posedge i_core_clk) begin
        o_status_accept <= 1'b0;
        o_status_stack <= 1'b0;
        cnt <= 0;
        if (i_status_valid && !o_status_accept && !o_status_stack) begin
            cnt <= cnt + 1;
            if (cnt == dly) begin
                o_status_accept <= !stack_mode;
                o_status_stack <= stack_mode;
            end
        end
    end
    // Select for one cycle, then offer the command byte for one cycle
    task send(input logic [7:0] c, input logic ch, input logic sl, input logic bad);
        if (sl) begin
            o_adapter_select <= 1'b1;
            @(posedge i_core_clk);
            o_adapter_select <= 1'b0;
        end
        o_cmd_valid <= 1'b1;
        o_cmd_byte <= c;
        o_cmd_parity <= ~^c ^ bad;
        o_cmd_chained <= ch;
        @(posedge i_core_clk);
        o_cmd_valid <= 1'b0;
        o_cmd_byte <= ~c; // Released byte no longer shows the command
    endtask : send
    // Raise or drop command out together with halt
    task halt_on(input logic v);
        o_command_out <= v;
        o_halt_io_request <= v;
    endtask : halt_on
endmodule : tces_host_model

/* tb.sv */
// Self-checking bench for the tape control sequencer
`timescale 1ns/1ps
module tb;
    import tces_pkg::*;
    logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00, o_rdata, o_status_byte, i_de_prime = 8'h00;
    logic i_op_done = 1'b0, i_tach_pulse = 1'b0, i_tu_ready = 1'b1, i_tu_start = 1'b1;
    logic i_at_load_point = 1'b0, i_tu_interrupt = 1'b0, i_tu_erase_fail = 1'b0;
    logic h_sel, h_cv, h_par, h_ch, h_co, h_halt, h_acc, h_stk;
    logic [7:0] h_cmd;
    logic o_service_in, o_move_tag, o_status_valid, o_tags_reset, o_metering_in;
    logic [2:0] o_tu_addr;
    logic sv_seen = 1'b0;
    int fails = 0, checks = 0, tg = 0, i;
    logic [7:0] tb_c [5] = '{8'h01, 8'h01, 8'h01, 8'h27, 8'h01};
    logic [7:0] tb_m [5] = '{8'h10, 8'h08, 8'h04, 8'h20, 8'h40};
    logic [7:0] sl_c [4] = '{8'h55, 8'h01, 8'h97, 8'h00};
    logic [7:0] sl_m [4] = '{8'h81, 8'h02, 8'h01, 8'h00};
    tces_ctrl #(.P_TACH_STOP_CYC(50), .P_UNITS(8)) u_tces_ctrl (.i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_adapter_select(h_sel), .i_cmd_valid(h_cv), .i_cmd_byte(h_cmd),
        .i_cmd_parity(h_par), .i_cmd_chained(h_ch), .i_command_out(h_co),
        .i_halt_io_request(h_halt), .i_status_accept(h_acc), .i_status_stack(h_stk),
        .i_op_done(i_op_done), .i_tach_pulse(i_tach_pulse), .i_tu_ready(i_tu_ready),
        .i_tu_start(i_tu_start), .i_at_load_point(i_at_load_point),
        .i_tu_interrupt(i_tu_interrupt), .i_tu_erase_fail(i_tu_erase_fail),
        .i_de_prime(i_de_prime), .o_service_in(o_service_in), .o_move_tag(o_move_tag),
        .o_status_valid(o_status_valid), .o_status_byte(o_status_byte),
        .o_tags_reset(o_tags_reset), .o_metering_in(o_metering_in), .o_tu_addr(o_tu_addr));
    tces_host_model u_tces_host_model (.i_core_clk(i_core_clk), .i_status_valid(o_status_valid),
        .o_adapter_select(h_sel), .o_cmd_valid(h_cv), .o_cmd_byte(h_cmd), .o_cmd_parity(h_par),
        .o_cmd_chained(h_ch), .o_command_out(h_co), .o_halt_io_request(h_halt),
        .o_status_accept(h_acc), .o_status_stack(h_stk));
    // ----------------------------------------------------------
    // Clock and status watcher
    // ----------------------------------------------------------
    always #2.5 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) if (o_status_valid === 1'b1) sv_seen <= 1'b1;
    // Report, verdict and stop
    task end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    // Compare one byte
    task chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Bounded wait for an event at the ports
    task wt(input int k, input int lim);
        logic hit;
        hit = 1'b0;
        for (int n = 0; n < lim && !hit; n++) begin
            @(posedge i_core_clk);
            #1;
            case (k)
                0: hit = (o_service_in === 1'b1 && o_move_tag === 1'b1);
                1: hit = (o_status_valid === 1'b1);
                2: hit = (o_tags_reset === 1'b1);
                3: hit = (o_metering_in === 1'b1);
                4: hit = (o_service_in === 1'b0 && o_move_tag === 1'b0);
                5: hit = (o_metering_in === 1'b0);
                default: hit = (o_tu_addr === 3'h2);
            endcase
        end
        checks++;
        if (!hit) begin
            fails++;
            $display("wrong value t=%0t wait %0d ran out", $time, k);
            end_sim;
        end
    endtask : wt
    // Register bus write and checked read
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata & m, e);
    endtask : rd
    // Reset for two cycles
    task rst;
        u_tces_host_model.stack_mode = 1'b0;
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        @(posedge i_core_clk);
    endtask : rst
    // Start a command, run n cycles with optional tach pair, then complete it
    task op(input logic [7:0] c, input logic ch, input logic sl, input int n);
        @(posedge i_core_clk);
        u_tces_host_model.send(c, ch, sl, 1'b0);
        wt(0, 8);
        if (tg > 0) begin
            i_tach_pulse <= 1'b1;
            @(posedge i_core_clk);
            i_tach_pulse <= 1'b0;
            repeat (tg) @(posedge i_core_clk);
            i_tach_pulse <= 1'b1;
            @(posedge i_core_clk);
            i_tach_pulse <= 1'b0;
        end
        repeat (n) @(posedge i_core_clk);
        i_op_done <= 1'b1;
        @(posedge i_core_clk);
        i_op_done <= 1'b0;
        wt(4, 3);
    endtask : op
    // Tape unit interrupt pulse
    task tu_int(input logic f);
        @(posedge i_core_clk);
        i_tu_interrupt <= 1'b1;
        i_tu_erase_fail <= f;
        @(posedge i_core_clk);
        i_tu_interrupt <= 1'b0;
        repeat (8) @(posedge i_core_clk);
    endtask : tu_int
    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        rst;
        rd(ADDR_CTRL, 8'hFF, CTRL_RESET);
        rd(ADDR_SENSE, 8'hFF, 8'h00);
        rd(4'hF, 8'hFF, 8'h00);
        wr(ADDR_CTRL, 8'h04);
        wt(6, 20);
        for (i = 0; i < 6; i++) begin
            @(posedge i_core_clk);
            #1;
            chk({5'h00, o_tu_addr}, 8'(i % 3));
        end
        i_de_prime <= 8'h08;
        wt(3, 3);
        i_de_prime <= 8'h00;
        wt(5, 3);
        wr(ADDR_CTRL, 8'h0E);
        op(CMD_WRITE, 1'b0, 1'b1, 5);
        wt(1, 10);
        chk(o_status_byte, 8'h0C);
        wt(2, 10);
        rd(ADDR_STATUS, 8'hFF, 8'h00);
        rd(ADDR_SENSE, 8'hFF, 8'h00);
        for (i = 0; i < 4; i++) begin
            @(posedge i_core_clk);
            u_tces_host_model.send(sl_c[i], 1'b0, 1'b1, i == 1);
            wt(1, 10);
            wt(2, 10);
            rd(ADDR_SENSE, sl_m[i], sl_m[i]);
        end
        for (i = 0; i < 5; i++) begin
            wr(ADDR_CTRL, (i == 4) ? 8'h0F : 8'h0E);
            tg = (i == 1) ? 3 : 0;
            i_tu_ready <= (i != 2);
            i_at_load_point <= (i == 3);
            op(tb_c[i], 1'b0, 1'b1, (i == 0) ? 60 : 5);
            wt(1, 10);
            chk(o_status_byte & 8'h02, 8'h02);
            wt(2, 10);
            rd(ADDR_SENSE, tb_m[i], tb_m[i]);
        end
        tg = 0;
        i_tu_ready <= 1'b1;
        i_at_load_point <= 1'b0;
        wr(ADDR_CTRL, 8'h0E);
        @(posedge i_core_clk);
        u_tces_host_model.send(CMD_WRITE, 1'b0, 1'b1, 1'b0);
        wt(0, 8);
        u_tces_host_model.halt_on(1'b1);
        sv_seen = 1'b0;
        wt(4, 4);
        wt(2, 10);
        chk({7'h00, sv_seen}, 8'h00);
        u_tces_host_model.halt_on(1'b0);
        rst;
        sv_seen = 1'b0;
        op(CMD_ERASE_GAP, 1'b1, 1'b1, 5);
        repeat (6) @(posedge i_core_clk);
        chk({7'h00, sv_seen}, 8'h00);
        op(CMD_SECURE_ERASE, 1'b1, 1'b0, 5);
        u_tces_host_model.o_cmd_chained <= 1'b0;
        wt(1, 10);
        chk(o_status_byte, 8'h08);
        chk({7'h00, o_metering_in}, 8'h01);
        wt(2, 10);
        u_tces_host_model.stack_mode = 1'b1;
        tu_int(1'b1);
        rd(ADDR_STATUS, 8'hFF, 8'h06);
        chk({7'h00, o_metering_in}, 8'h00);
        rst;
        op(CMD_REWIND, 1'b0, 1'b1, 5);
        wt(1, 10);
        chk(o_status_byte, 8'h08);
        chk({7'h00, o_metering_in}, 8'h01);
        wt(2, 10);
        u_tces_host_model.stack_mode = 1'b1;
        tu_int(1'b0);
        rd(ADDR_STATUS, 8'hFF, 8'h04);
        rst;
        u_tces_host_model.stack_mode = 1'b1;
        op(CMD_WRITE, 1'b0, 1'b1, 5);
        wt(1, 10);
        wt(2, 10);
        rd(ADDR_STATUS, 8'h0E, 8'h0C);
        end_sim;
    end
endmodule : tb
